// ==== verilog/bpcc_defs.svh ====
// Register offsets, field positions, reset values and rule notes for the breakpoint compare block
// Notes on behaviour
// [RL1] Comparator C bits select one or zero match
// [RL2] Arming in first loop clears comparator value
// [RL3] Paging low bit selects extended compare layout
// [RL4] A/B enable blocks setting trace debug enable
// [RL5] Trace mode without A/B ignores full, tag
// [RL6] C bits form third breakpoint except loop
// [RL7] Bit 6 selects dual or full mode
// [RL8] Bit 5 routes break to background/interrupt
// [RL9] Bit 4 forces or tags A/B break
// [RL10] Tagged break only for executed opcodes
// [RL11] Bit 3 enables comparator C breakpoint
// [RL12] Arming in first loop clears C enable
// [RL13] Bit 2 forces or tags C break
// [RL14] Bit 1 adds direction qualifier to C
// [RL15] Bit 0 picks read or write match
// [RL16] Paging codes 10/11 act as 00/01
// [RL17] Enabled match raises break request to core
`ifndef BPCC_DEFS_SVH
`define BPCC_DEFS_SVH
// Byte offsets are printed index times four
`define BPCC_IDX_EXT        6'h25
`define BPCC_IDX_HIGH       6'h26
`define BPCC_IDX_LOW        6'h27
`define BPCC_IDX_CTL2       6'h28
`define BPCC_IDX_CTL1       6'h30
`define BPCC_IDX_STAT       6'h31
`define BPCC_IDX_MASK       6'h32
// Control two fields
`define BPCC_AB_EN          7
`define BPCC_FULL           6
`define BPCC_BGND           5
`define BPCC_TAG_AB         4
`define BPCC_C_EN           3
`define BPCC_TAG_C          2
`define BPCC_RW_EN          1
`define BPCC_RW_VAL         0
// Control one fields (own register)
`define BPCC_C1_DBG_EN      7
`define BPCC_C1_ARM         6
`define BPCC_C1_FIRST_LOOP_CAPTURE       5
// Status fields
`define BPCC_ST_C_MATCH     0
`define BPCC_ST_BREAK       1
`define BPCC_RST_BYTE       8'h00
`define BPCC_RST_FLAGS      2'h0
`define BPCC_RST_WORD       32'h0
// Extended register fields
`define BPCC_PAGE_LOW       6
`endif

// ==== verilog/bpcc_pkg.sv ====
// Types shared by the breakpoint compare block
package bpcc_pkg;
  // Wishbone request from master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } bpcc_wb_req_s;
  // Core bus cycle being watched
  typedef struct packed {
    logic        valid;
    logic [21:0] addr;
    logic        read;
    logic        ab_match;
    logic        exec;
    logic        tag_ab_exec;
  } bpcc_core_s;
  // Break request toward core
  typedef struct packed {
    logic force_brk;
    logic tag_c;
    logic tag_ab;
    logic to_bgnd;
  } bpcc_brk_s;
endpackage

// ==== verilog/bpcc_top.sv ====
// Comparator C and control two registers with break request generation
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ns
`include "bpcc_defs.svh"
module bpcc_top (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  // Wishbone slave
  input  wire bpcc_pkg::bpcc_wb_req_s wb_req,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  // Core watch and break
  input  wire bpcc_pkg::bpcc_core_s core_i,
  output bpcc_pkg::bpcc_brk_s       brk_o,
  output logic                      full_mode_o,
  output logic                      ab_active_o,
  // Interrupt
  output logic                      irq_o
);
  import bpcc_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // All state resets synchronously to zero
  logic [7:0]  ext_r;        // Paging select and extended compare
  logic [7:0]  high_r;       // Comparator C high byte
  logic [7:0]  low_r;        // Comparator C low byte
  logic [7:0]  ctl2_r;       // Control two
  logic [7:0]  ctl1_r;       // Control one (debug enable, arm, loop)
  logic [1:0]  stat_r;       // Sticky events
  logic [1:0]  mask_r;       // Interrupt mask
  logic        ack_r;        // Bus ack
  logic [31:0] rdat_r;       // Read data
  bpcc_brk_s   brk_r;        // Break request
  logic        irq_r;        // Interrupt line

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic        acc;          // New access, taken this edge
  logic        wr;           // Write strobe, on the ack edge
  logic [5:0]  idx;          // Register index
  logic        arm_loop;     // Arming in first loop mode
  // A request is taken on the first edge that sees it with ack low
  assign acc      = wb_req.cyc & wb_req.stb & ~ack_r;
  // Writes land on the edge at which the master sees ack high,
  // while address and data are still held; a request dropped
  // before that edge writes nothing
  assign wr       = wb_req.cyc & wb_req.stb & ack_r & wb_req.we & wb_req.sel[0];
  assign idx      = wb_req.adr[7:2];
  // Arm and first loop written together start a loop capture
  assign arm_loop = wr && idx == `BPCC_IDX_CTL1 && wb_req.dat[`BPCC_C1_ARM] && wb_req.dat[`BPCC_C1_FIRST_LOOP_CAPTURE];

  // ----------------------------------------
  // Comparator match
  // ----------------------------------------
  // Returns comparator C address match for given page mode
  function automatic logic c_addr_hit(input logic [7:0] ext, input logic [7:0] hi,
                                      input logic [7:0] lo, input logic [21:0] a);
    // Only the low select bit matters, high bit ignored
    if (ext[`BPCC_PAGE_LOW]) // RL16
      // Paged: extended bits, then the sixteen value bits
      c_addr_hit = (ext[5:0] == a[21:16]) && ({hi, lo} == a[15:0]); // RL3
    else
      // Unpaged: the value bits alone against the core address
      c_addr_hit = ({hi, lo} == a[15:0]); // RL1
  endfunction

  logic c_hit;    // Qualified comparator C hit
  logic c_usable; // Comparator C may form a break
  logic dir_ok;   // Direction qualifier passes
  logic ab_on;    // A/B function active
  // Direction only counts when qualifying is on
  assign dir_ok   = ~ctl2_r[`BPCC_RW_EN] | (core_i.read == ctl2_r[`BPCC_RW_VAL]); // RL14 RL15
  // Loop capture under trace debug takes comparator C away
  assign c_usable = ctl2_r[`BPCC_C_EN] & ~(ctl1_r[`BPCC_C1_DBG_EN] & ctl1_r[`BPCC_C1_FIRST_LOOP_CAPTURE]); // RL6 RL11
  // Watched cycle, enable, direction and address all agree
  assign c_hit    = core_i.valid & c_usable & dir_ok & c_addr_hit(ext_r, high_r, low_r, core_i.addr);
  // The A/B function gates full mode and the A/B tag select
  assign ab_on    = ctl2_r[`BPCC_AB_EN]; // RL4 RL5

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Extended and comparator value; first loop arming clears value
  // The low byte has no reset value of its own; zero is used
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ext_r  <= `BPCC_RST_BYTE;
      high_r <= `BPCC_RST_BYTE;
      low_r  <= `BPCC_RST_BYTE;
    end else if (arm_loop) begin
      high_r <= `BPCC_RST_BYTE; // RL2
      low_r  <= `BPCC_RST_BYTE; // RL2
    end else if (wr) begin
      if (idx == `BPCC_IDX_EXT)  ext_r  <= wb_req.dat[7:0];
      if (idx == `BPCC_IDX_HIGH) high_r <= wb_req.dat[7:0];
      if (idx == `BPCC_IDX_LOW)  low_r  <= wb_req.dat[7:0];
    end
  end

  // Control two; arming in first loop clears C enable
  // Arming is a control one write, so it never meets a control two write
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctl2_r <= `BPCC_RST_BYTE;
    end else if (wr && idx == `BPCC_IDX_CTL2) begin
      ctl2_r <= wb_req.dat[7:0];
    end else if (arm_loop) begin
      ctl2_r[`BPCC_C_EN] <= 1'b0; // RL12
    end
  end

  // Control one; debug enable cannot be set while A/B on
  // Only the debug enable bit is held back; other bits land
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctl1_r <= `BPCC_RST_BYTE;
    end else if (wr && idx == `BPCC_IDX_CTL1) begin
      ctl1_r <= wb_req.dat[7:0];
      if (ab_on) ctl1_r[`BPCC_C1_DBG_EN] <= 1'b0; // RL4
    end
  end

  // Status events and software clears
  logic [1:0]  stat_set;     // Events seen this cycle
  logic [1:0]  stat_clr;     // Ones written to status
  // Break pulse in bit 1, comparator C hit in bit 0
  assign stat_set = {brk_r.force_brk | brk_r.tag_c | brk_r.tag_ab, c_hit};
  // A write of ones clears; other bits are left alone
  assign stat_clr = (wr && idx == `BPCC_IDX_STAT) ? wb_req.dat[1:0] : `BPCC_RST_FLAGS;
  // Sticky status, set wins over clear so no event is lost
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stat_r <= `BPCC_RST_FLAGS;
      mask_r <= `BPCC_RST_FLAGS;
    end else begin
      // Mask is a plain read/write register
      if (wr && idx == `BPCC_IDX_MASK) mask_r <= wb_req.dat[1:0];
      stat_r <= (stat_r & ~stat_clr) | stat_set;
    end
  end

  // ----------------------------------------
  // Break generation
  // ----------------------------------------
  // Forced or tagged break requests from comparators
  // Tagged requests wait for the core to execute the opcode
  // Each request is a one-cycle pulse; the routing is a level
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      brk_r <= '0;
    end else begin
      brk_r.to_bgnd   <= ctl2_r[`BPCC_BGND]; // RL8
      brk_r.force_brk <= (c_hit & ~ctl2_r[`BPCC_TAG_C])
                       | (ab_on & core_i.ab_match & ~ctl2_r[`BPCC_TAG_AB]); // RL9 RL13 RL17
      brk_r.tag_c     <= c_hit & ctl2_r[`BPCC_TAG_C] & core_i.exec; // RL10 RL13
      brk_r.tag_ab    <= ab_on & ctl2_r[`BPCC_TAG_AB] & core_i.tag_ab_exec; // RL9 RL10
    end
  end

  // Mode outputs; full mode only meaningful with A/B enabled
  // Interrupt follows unmasked status one cycle late
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      full_mode_o <= 1'b0;
      ab_active_o <= 1'b0;
      irq_r       <= 1'b0;
    end else begin
      full_mode_o <= ab_on & ctl2_r[`BPCC_FULL]; // RL5 RL7
      ab_active_o <= ab_on;
      irq_r       <= |(stat_r & mask_r);
    end
  end

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  // One-wait ack and read mux; unmapped reads zero
  // Read data loads at the taking edge and holds till the next access
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_r  <= 1'b0;
      rdat_r <= `BPCC_RST_WORD;
    end else begin
      ack_r <= acc;
      if (acc) begin
        unique case (idx)
          `BPCC_IDX_EXT:  rdat_r <= {24'h0, ext_r};
          `BPCC_IDX_HIGH: rdat_r <= {24'h0, high_r};
          `BPCC_IDX_LOW:  rdat_r <= {24'h0, low_r};
          `BPCC_IDX_CTL2: rdat_r <= {24'h0, ctl2_r};
          `BPCC_IDX_CTL1: rdat_r <= {24'h0, ctl1_r};
          `BPCC_IDX_STAT: rdat_r <= {30'h0, stat_r};
          `BPCC_IDX_MASK: rdat_r <= {30'h0, mask_r};
          default:        rdat_r <= 32'h0;
        endcase
      end
    end
  end

  // Every output comes straight from a flop
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign brk_o    = brk_r;
  assign irq_o    = irq_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Arming with the first loop capture selected
  sequence s_arm;
    arm_loop;
  endsequence
  // Comparator C hit that its tag setting lets through now
  sequence s_c_take;
    c_hit && (!ctl2_r[`BPCC_TAG_C] || core_i.exec);
  endsequence
  // Break pulse from comparator C on the next cycle
  sequence s_c_break;
    brk_o.force_brk || brk_o.tag_c;
  endsequence
  // Forced A/B hit while the A/B function is on
  sequence s_ab_force;
    ab_on && core_i.ab_match && !ctl2_r[`BPCC_TAG_AB];
  endsequence
  // Bus request taken by the slave on this edge
  sequence s_take;
    acc;
  endsequence

  // Arming and register protection
  // Value reads zero right after loop arming
  property p_clear_val;
    @(posedge sys_clk) disable iff (reset) s_arm |=> ({high_r, low_r} == 16'h0);
  endproperty
  a_clear_val: assert property (p_clear_val) else $error("value not cleared"); // RL2
  // C enable drops right after loop arming
  property p_clear_en;
    @(posedge sys_clk) disable iff (reset)
      (arm_loop && !(wr && idx == `BPCC_IDX_CTL2)) |=> !ctl2_r[`BPCC_C_EN];
  endproperty
  a_clear_en: assert property (p_clear_en) else $error("C enable not cleared"); // RL12
  // A control one write while the A/B function is on leaves debug enable clear
  property p_dbg_block;
    @(posedge sys_clk) disable iff (reset) (wr && idx == `BPCC_IDX_CTL1 && ab_on) |=> !ctl1_r[`BPCC_C1_DBG_EN];
  endproperty
  a_dbg_block: assert property (p_dbg_block) else $error("debug enable set"); // RL4
  // Value bytes only change by a write or by loop arming
  property p_val_keep;
    @(posedge sys_clk) disable iff (reset) (!wr && !arm_loop) |=> $stable({high_r, low_r});
  endproperty
  a_val_keep: assert property (p_val_keep) else $error("value changed"); // RL1
  // Control two only changes by a write or by loop arming
  property p_ctl_keep;
    @(posedge sys_clk) disable iff (reset) (!wr && !arm_loop) |=> $stable(ctl2_r);
  endproperty
  a_ctl_keep: assert property (p_ctl_keep) else $error("control two changed");

  // Comparator C
  // A hit means the value bits equal the core address bits
  property p_val_cmp;
    @(posedge sys_clk) disable iff (reset) c_hit |-> ({high_r, low_r} == core_i.addr[15:0]);
  endproperty
  a_val_cmp: assert property (p_val_cmp) else $error("value compare wrong"); // RL1
  // Paged hits also agree on the extended bits
  property p_ext_cmp;
    @(posedge sys_clk) disable iff (reset) (c_hit && ext_r[`BPCC_PAGE_LOW]) |-> (core_i.addr[21:16] == ext_r[5:0]);
  endproperty
  a_ext_cmp: assert property (p_ext_cmp) else $error("extended compare wrong"); // RL3
  // No comparator C break while its enable is clear
  property p_no_c;
    @(posedge sys_clk) disable iff (reset)
      (!ctl2_r[`BPCC_C_EN] && !(ab_on && core_i.ab_match)) |=> !brk_o.force_brk && !brk_o.tag_c;
  endproperty
  a_no_c: assert property (p_no_c) else $error("C hit while off"); // RL11
  // A cycle of the wrong direction raises no comparator C break
  property p_dir;
    @(posedge sys_clk) disable iff (reset)
      (core_i.valid && ctl2_r[`BPCC_RW_EN] && core_i.read != ctl2_r[`BPCC_RW_VAL] && !(ab_on && core_i.ab_match))
      |=> !brk_o.force_brk && !brk_o.tag_c;
  endproperty
  a_dir: assert property (p_dir) else $error("direction mismatch"); // RL15
  // Loop capture under trace debug silences comparator C
  property p_usable;
    @(posedge sys_clk) disable iff (reset)
      (ctl1_r[`BPCC_C1_DBG_EN] && ctl1_r[`BPCC_C1_FIRST_LOOP_CAPTURE] && !ab_on) |=> !brk_o.force_brk && !brk_o.tag_c;
  endproperty
  a_usable: assert property (p_usable) else $error("C used in loop capture"); // RL6
  // A taken comparator C hit requests a break next cycle
  property p_c_break;
    @(posedge sys_clk) disable iff (reset) s_c_take |=> s_c_break;
  endproperty
  a_c_break: assert property (p_c_break) else $error("no break request"); // RL17
  // Forced comparator C hit gives a forced break
  property p_force_c;
    @(posedge sys_clk) disable iff (reset) (c_hit && !ctl2_r[`BPCC_TAG_C]) |=> brk_o.force_brk;
  endproperty
  a_force_c: assert property (p_force_c) else $error("no forced break"); // RL13
  // Tagged comparator C hit never forces a break
  property p_tag_c_only;
    @(posedge sys_clk) disable iff (reset)
      (c_hit && ctl2_r[`BPCC_TAG_C] && !(ab_on && core_i.ab_match)) |=> !brk_o.force_brk;
  endproperty
  a_tag_c_only: assert property (p_tag_c_only) else $error("tagged hit forced"); // RL13
  // A tagged C break needs an executed opcode
  property p_tag_exec;
    @(posedge sys_clk) disable iff (reset) brk_o.tag_c |-> $past(core_i.exec);
  endproperty
  a_tag_exec: assert property (p_tag_exec) else $error("tag w/o exec"); // RL10

  // Comparators A and B, routing
  // Forced A/B hit gives a forced break
  property p_ab_force;
    @(posedge sys_clk) disable iff (reset) s_ab_force |=> brk_o.force_brk;
  endproperty
  a_ab_force: assert property (p_ab_force) else $error("no A/B forced break"); // RL9
  // A tagged A/B break needs an executed opcode
  property p_ab_tag;
    @(posedge sys_clk) disable iff (reset) brk_o.tag_ab |-> $past(core_i.tag_ab_exec);
  endproperty
  a_ab_tag: assert property (p_ab_tag) else $error("A/B tag w/o exec"); // RL10
  // No A/B tagged break while the A/B function is off
  property p_ab_off;
    @(posedge sys_clk) disable iff (reset) !ab_on |=> !brk_o.tag_ab;
  endproperty
  a_ab_off: assert property (p_ab_off) else $error("A/B tag while off"); // RL5
  // Full mode only shows with the A/B function on
  property p_full;
    @(posedge sys_clk) disable iff (reset) full_mode_o |-> $past(ab_on);
  endproperty
  a_full: assert property (p_full) else $error("full without A/B"); // RL5
  // Full select with A/B on shows full mode
  property p_full_on;
    @(posedge sys_clk) disable iff (reset) (ab_on && ctl2_r[`BPCC_FULL]) |=> full_mode_o;
  endproperty
  a_full_on: assert property (p_full_on) else $error("full mode missing"); // RL7
  // A/B enable is shown one cycle later
  property p_ab_active;
    @(posedge sys_clk) disable iff (reset) ab_on |=> ab_active_o;
  endproperty
  a_ab_active: assert property (p_ab_active) else $error("A/B active missing"); // RL4
  // Background routing follows its control bit
  property p_bgnd_on;
    @(posedge sys_clk) disable iff (reset) ctl2_r[`BPCC_BGND] |=> brk_o.to_bgnd;
  endproperty
  a_bgnd_on: assert property (p_bgnd_on) else $error("routing not background"); // RL8
  // Interrupt routing when the bit is clear
  property p_bgnd_off;
    @(posedge sys_clk) disable iff (reset) !ctl2_r[`BPCC_BGND] |=> !brk_o.to_bgnd;
  endproperty
  a_bgnd_off: assert property (p_bgnd_off) else $error("routing not interrupt"); // RL8

  // Status and interrupt
  // A comparator C hit is kept in status
  property p_sticky;
    @(posedge sys_clk) disable iff (reset) c_hit |=> stat_r[`BPCC_ST_C_MATCH];
  endproperty
  a_sticky: assert property (p_sticky) else $error("match not recorded");
  // Any break pulse is kept in status
  property p_break_stat;
    @(posedge sys_clk) disable iff (reset) (brk_o.force_brk || brk_o.tag_c || brk_o.tag_ab) |=> stat_r[`BPCC_ST_BREAK];
  endproperty
  a_break_stat: assert property (p_break_stat) else $error("break not recorded");
  // Writing a one clears the match bit when no hit meets it
  property p_clr_stat;
    @(posedge sys_clk) disable iff (reset)
      (wr && idx == `BPCC_IDX_STAT && wb_req.dat[`BPCC_ST_C_MATCH] && !c_hit) |=> !stat_r[`BPCC_ST_C_MATCH];
  endproperty
  a_clr_stat: assert property (p_clr_stat) else $error("match not cleared");
  // Unmasked status raises the interrupt
  property p_irq_on;
    @(posedge sys_clk) disable iff (reset) (|(stat_r & mask_r)) |=> irq_o;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt missing");
  // No unmasked status, no interrupt
  property p_irq_off;
    @(posedge sys_clk) disable iff (reset) !(|(stat_r & mask_r)) |=> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt spurious");

  // Register bus
  // A taken request is answered after one wait
  property p_ack_resp;
    @(posedge sys_clk) disable iff (reset) s_take |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
  // Ack is a single-cycle pulse
  property p_ack;
    @(posedge sys_clk) disable iff (reset) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held");
endmodule // bpcc_top

// ==== sim/bpcc_core_model.sv ====
// Behavioural processor core bus presenting watched cycles to the block
`timescale 1ns/1ns
module bpcc_core_model (
  // Clock
  input  wire logic              sys_clk,
  // Watched bus cycle
  output bpcc_pkg::bpcc_core_s   core_o
);
  import bpcc_pkg::*;
  // Bus idle at start
  initial core_o = '0;
  // One cycle on the bus, then released; a released bus shows the inverted address
  task automatic bus_cycle(input logic [21:0] a, input logic rd, ab, ex, tab);
    @(posedge sys_clk);
    core_o <= '{valid: 1'b1, addr: a, read: rd, ab_match: ab, exec: ex, tag_ab_exec: tab};
    @(posedge sys_clk);
    core_o <= '{valid: 1'b0, addr: ~a, read: ~rd, ab_match: 1'b0, exec: 1'b0, tag_ab_exec: 1'b0};
  endtask
endmodule // bpcc_core_model

// ==== sim/bpcc_top_tb.sv ====
// Self-checking bench for the breakpoint compare block
`timescale 1ns/1ns
module bpcc_top_tb;
  import bpcc_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic          sys_clk;
  logic          reset;
  bpcc_wb_req_s  wb_req;
  logic [31:0]   wb_dat_o;
  logic          wb_ack_o;
  bpcc_core_s    core_i;
  bpcc_brk_s     brk_o;
  logic          full_mode_o;
  logic          ab_active_o;
  logic          irq_o;
  int            n_fail;
  int            n_checks;
  int            n_cyc;
  bpcc_top i_bpcc_top (.sys_clk(sys_clk), .reset(reset), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .core_i(core_i), .brk_o(brk_o), .full_mode_o(full_mode_o),
    .ab_active_o(ab_active_o), .irq_o(irq_o));
  bpcc_core_model i_bpcc_core_model (.sys_clk(sys_clk), .core_o(core_i));
  // Clock, 4 ns period
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Cycle ceiling against a hang
  always @(posedge sys_clk) begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 5000) begin
      n_fail++;
      end_of_test();
    end
  end
  // Value and break comparisons
  task automatic chk_val(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_brk(input bpcc_brk_s got, exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t brk got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One classic bus cycle, held until ack is sampled high
  task automatic wb_cyc(input logic we, input logic [7:0] adr, d, output logic [31:0] q);
    @(posedge sys_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h000000, d}};
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_req <= '0;
  endtask
  task automatic wr(input logic [7:0] adr, d);
    logic [31:0] q;
    wb_cyc(1'b1, adr, d, q);
  endtask
  task automatic rd(input logic [7:0] adr, exp);
    logic [31:0] q;
    wb_cyc(1'b0, adr, 8'h00, q);
    chk_val(q, {24'h000000, exp});
  endtask
  // Core cycle with flags {read, ab hit, exec, ab exec}; break checked after the sampling edge
  task automatic hit(input logic [21:0] a, input logic [3:0] f, input logic [3:0] e);
    i_bpcc_core_model.bus_cycle(a, f[3], f[2], f[1], f[0]);
    #1 chk_brk(brk_o, e);
  endtask
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  // Verdict and end of run
  task automatic end_of_test();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    n_fail = 0;
    n_checks = 0;
    n_cyc = 0;
    reset = 1'b1;
    wb_req = '0;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    rd(8'h98, 8'h00);
    rd(8'ha0, 8'h00);
    rd(8'hfc, 8'h00);
    $display("test reset done");
    wr(8'h94, 8'h00);
    wr(8'h98, 8'h12);
    wr(8'h9c, 8'h34);
    wr(8'ha0, 8'h08);
    hit(22'h001234, 4'h0, 4'h8);
    hit(22'h001235, 4'h0, 4'h0);
    wr(8'ha0, 8'h0b);
    hit(22'h001234, 4'h0, 4'h0);
    hit(22'h001234, 4'h8, 4'h8);
    wr(8'ha0, 8'h09);
    hit(22'h001234, 4'h0, 4'h8);
    wr(8'ha0, 8'h0c);
    hit(22'h001234, 4'h2, 4'h4);
    hit(22'h001234, 4'h0, 4'h0);
    wr(8'ha0, 8'h28);
    hit(22'h001234, 4'h0, 4'h9);
    $display("test comp c done");
    wr(8'h94, 8'h45);
    hit(22'h051234, 4'h0, 4'h9);
    hit(22'h061234, 4'h0, 4'h1);
    wr(8'h94, 8'hc5);
    hit(22'h061234, 4'h0, 4'h1);
    wr(8'h94, 8'h85);
    hit(22'h061234, 4'h0, 4'h9);
    rd(8'h94, 8'h85);
    $display("test paging done");
    wr(8'ha0, 8'h40);
    hit(22'h000000, 4'h4, 4'h0);
    chk_val(full_mode_o, 1'b0);
    wr(8'ha0, 8'hc0);
    settle();
    chk_val({full_mode_o, ab_active_o}, 2'b11);
    hit(22'h000000, 4'h4, 4'h8);
    wr(8'ha0, 8'h90);
    hit(22'h000000, 4'h1, 4'h2);
    hit(22'h000000, 4'h4, 4'h0);
    chk_val(full_mode_o, 1'b0);
    wr(8'hc0, 8'h80);
    rd(8'hc0, 8'h00);
    $display("test ab done");
    wr(8'ha0, 8'h08);
    wr(8'hc0, 8'ha0);
    hit(22'h001234, 4'h0, 4'h0);
    wr(8'hc0, 8'h00);
    wr(8'hc4, 8'h03);
    wr(8'hc8, 8'h01);
    settle();
    chk_val(irq_o, 1'b0);
    hit(22'h001234, 4'h0, 4'h8);
    settle();
    chk_val(irq_o, 1'b1);
    rd(8'hc4, 8'h03);
    wr(8'hc4, 8'h03);
    wr(8'hc8, 8'h00);
    hit(22'h001234, 4'h0, 4'h8);
    settle();
    chk_val(irq_o, 1'b0);
    $display("test irq done");
    wr(8'hc0, 8'h60);
    rd(8'h98, 8'h00);
    rd(8'h9c, 8'h00);
    rd(8'ha0, 8'h00);
    $display("test arm done");
    end_of_test();
  end
endmodule // bpcc_top_tb
